//--- src/mts_top.sv
// Trigger sequencer: trigger sources in, reading requests out,
// delay timing, sample/trigger counting and reading hold.
// Assumes keys, ext trigger and front end are synchronous to sys_clk_i.
`timescale 1ns/100ps
`default_nettype none
`include "mts_map.svh"

module mts_top (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire mts_pkg::mts_keys_t keys_i,
    input wire logic external_trigger_input_i,
    input wire mts_pkg::mts_reading_t meas_i,
    output logic meas_start_o,
    output mts_pkg::mts_disp_t disp_o,
    output logic beep_o,
    output logic trigger_settings_menu_ready_o
);

    mts_pkg::mts_state_t state_q;
    mts_pkg::mts_src_t src_q;
    mts_pkg::mts_meas_cfg_t cfg_q;
    logic auto_dly_q;
    logic [25:0] delay_q;
    logic [15:0] scount_q;
    logic [15:0] tcount_q;
    logic [23:0] band_q;
    logic hold_en_q;
    logic held_q;
    logic arm_q;
    logic sw_trigger_settings_menu_q;
    logic ext_q;
    logic [11:0] pre_q;
    logic [25:0] dly_cnt_q;
    logic [15:0] samp_q;
    logic [15:0] trigger_settings_menu_q;
    logic [1:0] run_q;
    logic [23:0] ref_q;
    logic [31:0] rdata_q;
    logic start_q;
    logic beep_q;
    mts_pkg::mts_disp_t disp_q;

    logic wr_ctrl;
    logic ext_rise;
    logic trigger_settings_menu_event;
    logic tick;
    logic [25:0] eff_delay;
    logic [24:0] diff;
    logic [23:0] abs_diff;

    assign wr_ctrl = reg_wr_i && reg_addr_i == `MTS_OFF_CTRL;
    assign ext_rise = external_trigger_input_i && !ext_q;
    assign tick = pre_q == 12'(`MTS_TICK_CYC - 1);

    // Automatic settling delay lookup, in ticks
    function automatic logic [25:0] auto_delay(
        input mts_pkg::mts_meas_cfg_t c,
        input logic fp_auto
    );
        logic [25:0] t;
        t = 26'(`MTS_DLY_TICKS(`MTS_DLY_1P0MS_US));
        unique case (c.func)
            mts_pkg::MTS_FN_DC: begin
                t = c.plc_ge1 ? 26'(`MTS_DLY_TICKS(`MTS_DLY_1P5MS_US))
                              : 26'(`MTS_DLY_TICKS(`MTS_DLY_1P0MS_US));
            end
            mts_pkg::MTS_FN_RES: begin
                if (c.res_rng[1]) begin
                    t = 26'(`MTS_DLY_TICKS(`MTS_DLY_100MS_US));
                end else if (c.res_rng[0]) begin
                    t = c.plc_ge1 ? 26'(`MTS_DLY_TICKS(`MTS_DLY_15MS_US))
                                  : 26'(`MTS_DLY_TICKS(`MTS_DLY_10MS_US));
                end else begin
                    t = c.plc_ge1 ? 26'(`MTS_DLY_TICKS(`MTS_DLY_1P5MS_US))
                                  : 26'(`MTS_DLY_TICKS(`MTS_DLY_1P0MS_US));
                end
            end
            mts_pkg::MTS_FN_AC: begin
                // Filter codes 0/1/2 are 3/20/200 Hz; 3 treated as 200 Hz
                if (fp_auto) begin
                    t = c.ac_filt == 2'h0 ? 26'(`MTS_DLY_TICKS(`MTS_DLY_1P5S_US))
                      : c.ac_filt == 2'h1 ? 26'(`MTS_DLY_TICKS(`MTS_DLY_200MS_US))
                      : 26'(`MTS_DLY_TICKS(`MTS_DLY_100MS_US));
                end else begin
                    t = c.ac_filt == 2'h0 ? 26'(`MTS_DLY_TICKS(`MTS_DLY_7P0S_US))
                      : c.ac_filt == 2'h1 ? 26'(`MTS_DLY_TICKS(`MTS_DLY_1P0S_US))
                      : 26'(`MTS_DLY_TICKS(`MTS_DLY_600MS_US));
                end
            end
            mts_pkg::MTS_FN_FREQ: begin
                t = fp_auto ? 26'h0000000
                            : 26'(`MTS_DLY_TICKS(`MTS_DLY_1P0S_US));
            end
        endcase
        return t;
    endfunction

    assign eff_delay = auto_dly_q ? auto_delay(cfg_q, src_q == mts_pkg::MTS_SRC_AUTO)
                                  : delay_q;

    always_comb begin
        unique case (src_q)
            mts_pkg::MTS_SRC_AUTO: trigger_settings_menu_event = 1'b1;
            mts_pkg::MTS_SRC_IMMEDIATE: trigger_settings_menu_event = 1'b1;
            mts_pkg::MTS_SRC_SINGLE: trigger_settings_menu_event = keys_i.single && !keys_i.shift;
            mts_pkg::MTS_SRC_EXTERNAL: trigger_settings_menu_event = ext_rise;
            mts_pkg::MTS_SRC_BUS: trigger_settings_menu_event = sw_trigger_settings_menu_q;
            default: trigger_settings_menu_event = 1'b0;
        endcase
    end

    assign diff = {1'b0, meas_i.data} - {1'b0, ref_q};
    assign abs_diff = meas_i.data >= ref_q ? diff[23:0] : 24'(-diff);

    // Trigger source: front panel keys and remote writes
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            src_q <= mts_pkg::MTS_SRC_AUTO;
        end else if (keys_i.auto_trigger_settings_menu && !keys_i.shift) begin
            src_q <= mts_pkg::MTS_SRC_AUTO;
        end else if (keys_i.single) begin
            src_q <= keys_i.shift ? mts_pkg::MTS_SRC_EXTERNAL
                                  : mts_pkg::MTS_SRC_SINGLE;
        end else if (wr_ctrl && reg_wdata_i[2:0] <= 3'h4) begin
            src_q <= mts_pkg::mts_src_t'(reg_wdata_i[2:0]);
        end
    end

    // Hold enable is reachable from the keys only
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hold_en_q <= 1'b0;
        end else if (keys_i.auto_trigger_settings_menu) begin
            hold_en_q <= keys_i.shift;
        end
    end

    // Delay settings; all volatile
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            auto_dly_q <= 1'b1;
            delay_q <= 26'h0000000;
        end else if (wr_ctrl) begin
            auto_dly_q <= reg_wdata_i[`MTS_CTRL_AUTO_DLY];
        end else if (reg_wr_i && reg_addr_i == `MTS_OFF_DELAY
                     && reg_wdata_i <= 32'(`MTS_DELAY_MAX)) begin
            delay_q <= reg_wdata_i[25:0];
            auto_dly_q <= 1'b0;
        end
    end

    // Counts, measurement setup and hold band
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scount_q <= `MTS_SCOUNT_RST;
            tcount_q <= `MTS_TCOUNT_RST;
            band_q <= `MTS_BAND_RST;
            cfg_q <= '0;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                `MTS_OFF_SCOUNT: begin
                    // Out of range counts are ignored
                    if (reg_wdata_i[31:16] == 16'h0000 && reg_wdata_i[15:0] != 16'h0000
                        && reg_wdata_i[15:0] <= `MTS_SCOUNT_MAX) begin
                        scount_q <= reg_wdata_i[15:0];
                    end
                end
                `MTS_OFF_TCOUNT: begin
                    if (reg_wdata_i[15:0] != 16'h0000) begin
                        tcount_q <= reg_wdata_i[15:0];
                    end
                end
                `MTS_OFF_BAND: band_q <= reg_wdata_i[23:0];
                `MTS_OFF_MEAS: cfg_q <= {reg_wdata_i[`MTS_MEAS_FUNC_LSB +: 2],
                    reg_wdata_i[`MTS_MEAS_PLC],
                    reg_wdata_i[`MTS_MEAS_RNG_LSB +: 2],
                    reg_wdata_i[`MTS_MEAS_FILT_LSB +: 2]};
                default: begin
                end
            endcase
        end
    end

    // One-cycle commands from CTRL, and the external trigger input delayed one cycle for edge detection
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            arm_q <= 1'b0;
            sw_trigger_settings_menu_q <= 1'b0;
            ext_q <= 1'b0;
        end else begin
            arm_q <= wr_ctrl && reg_wdata_i[`MTS_CTRL_ARM];
            sw_trigger_settings_menu_q <= wr_ctrl && reg_wdata_i[`MTS_CTRL_SWTRIG];
            ext_q <= external_trigger_input_i;
        end
    end

    // Tick prescaler, restarted at the delay start so waits never run short
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pre_q <= 12'h000;
        end else if (state_q != mts_pkg::MTS_ST_DELAY || tick) begin
            pre_q <= 12'h000;
        end else begin
            pre_q <= pre_q + 12'h001;
        end
    end

    // Sequencer
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= mts_pkg::MTS_ST_IDLE;
            dly_cnt_q <= 26'h0000000;
            samp_q <= 16'h0000;
            trigger_settings_menu_q <= 16'h0000;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            unique case (state_q)
                mts_pkg::MTS_ST_IDLE: begin
                    trigger_settings_menu_q <= 16'h0000;
                    // Remote sources need an arm; panel sources rearm alone
                    if (arm_q || src_q == mts_pkg::MTS_SRC_AUTO
                        || src_q == mts_pkg::MTS_SRC_SINGLE
                        || src_q == mts_pkg::MTS_SRC_EXTERNAL) begin
                        state_q <= mts_pkg::MTS_ST_WAIT;
                    end
                end
                mts_pkg::MTS_ST_WAIT: begin
                    samp_q <= 16'h0000;
                    if (trigger_settings_menu_event) begin
                        dly_cnt_q <= eff_delay;
                        state_q <= eff_delay == 26'h0000000
                                   ? mts_pkg::MTS_ST_REQ
                                   : mts_pkg::MTS_ST_DELAY;
                    end
                end
                mts_pkg::MTS_ST_DELAY: begin
                    if (tick) begin
                        dly_cnt_q <= dly_cnt_q - 26'h0000001;
                        if (dly_cnt_q == 26'h0000001) begin
                            state_q <= mts_pkg::MTS_ST_REQ;
                        end
                    end
                end
                mts_pkg::MTS_ST_REQ: begin
                    start_q <= 1'b1;
                    state_q <= mts_pkg::MTS_ST_READ;
                end
                mts_pkg::MTS_ST_READ: begin
                    if (meas_i.valid) begin
                        samp_q <= samp_q + 16'h0001;
                        if (samp_q + 16'h0001 != scount_q) begin
                            state_q <= mts_pkg::MTS_ST_REQ;
                        end else if (trigger_settings_menu_q + 16'h0001 != tcount_q) begin
                            trigger_settings_menu_q <= trigger_settings_menu_q + 16'h0001;
                            state_q <= mts_pkg::MTS_ST_WAIT;
                        end else if (src_q == mts_pkg::MTS_SRC_AUTO) begin
                            trigger_settings_menu_q <= 16'h0000;
                            state_q <= mts_pkg::MTS_ST_WAIT;
                        end else begin
                            state_q <= mts_pkg::MTS_ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Reading hold and display
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_q <= 2'h0;
            ref_q <= 24'h000000;
            held_q <= 1'b0;
            beep_q <= 1'b0;
            disp_q <= '0;
        end else begin
            beep_q <= 1'b0;
            disp_q.hold <= hold_en_q;
            if (!hold_en_q) begin
                run_q <= 2'h0;
                held_q <= 1'b0;
                if (meas_i.valid) begin
                    disp_q.value <= meas_i.data;
                end
            end else if (meas_i.valid) begin
                if (run_q == 2'h0 || abs_diff > band_q) begin
                    ref_q <= meas_i.data;
                    run_q <= 2'h1;
                end else if (run_q == 2'h2) begin
                    // Third reading in band: freeze and restart the run
                    disp_q.value <= meas_i.data;
                    held_q <= 1'b1;
                    beep_q <= 1'b1;
                    run_q <= 2'h0;
                end else begin
                    run_q <= run_q + 2'h1;
                end
            end
        end
    end

    // Register read port, data valid the cycle after the strobe
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 32'h00000000;
        end else if (!reg_rd_i) begin
            rdata_q <= 32'h00000000;
        end else begin
            unique case (reg_addr_i)
                `MTS_OFF_CTRL: rdata_q <= {28'h0000000, auto_dly_q, src_q};
                `MTS_OFF_MEAS: rdata_q <= {25'h0000000, cfg_q.ac_filt,
                    cfg_q.res_rng, cfg_q.plc_ge1, cfg_q.func};
                `MTS_OFF_SCOUNT: rdata_q <= {16'h0000, scount_q};
                `MTS_OFF_TCOUNT: rdata_q <= {16'h0000, tcount_q};
                `MTS_OFF_DELAY: rdata_q <= {6'h00, delay_q};
                `MTS_OFF_BAND: rdata_q <= {8'h00, band_q};
                `MTS_OFF_STATUS: rdata_q <= {11'h000, trigger_settings_menu_q, held_q,
                                             hold_en_q, state_q};
                `MTS_OFF_HELD: rdata_q <= {8'h00, disp_q.value};
                default: rdata_q <= 32'h00000000;
            endcase
        end
    end

    assign reg_rdata_o = rdata_q;
    assign meas_start_o = start_q;
    assign disp_o = disp_q;
    assign beep_o = beep_q;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            trigger_settings_menu_ready_o <= 1'b0;
        end else begin
            trigger_settings_menu_ready_o <= state_q == mts_pkg::MTS_ST_WAIT;
        end
    end

endmodule // mts_top
`default_nettype wire

//--- include/mts_map.svh
// Register offsets, field positions, reset values and timing counts
// of the trigger sequencer. Included by the package and the design.
`ifndef MTS_MAP_SVH
`define MTS_MAP_SVH

`define MTS_ADDR_W 5
`define MTS_OFF_CTRL 5'h00
`define MTS_OFF_MEAS 5'h04
`define MTS_OFF_SCOUNT 5'h08
`define MTS_OFF_TCOUNT 5'h0c
`define MTS_OFF_DELAY 5'h10
`define MTS_OFF_BAND 5'h14
`define MTS_OFF_STATUS 5'h18
`define MTS_OFF_HELD 5'h1c

// CTRL fields
`define MTS_CTRL_SRC_LSB 0
`define MTS_CTRL_AUTO_DLY 3
`define MTS_CTRL_ARM 4
`define MTS_CTRL_SWTRIG 5
// MEAS fields
`define MTS_MEAS_FUNC_LSB 0
`define MTS_MEAS_PLC 2
`define MTS_MEAS_RNG_LSB 3
`define MTS_MEAS_FILT_LSB 5

`define MTS_SCOUNT_RST 16'h0001
`define MTS_SCOUNT_MAX 16'hc350
`define MTS_TCOUNT_RST 16'h0001
`define MTS_BAND_RST 24'h000000
`define MTS_DELAY_MAX 26'h2255100

// Delay base: one tick is 100 us
`define MTS_CLK_HZ 40000000
`define MTS_TICK_US 100
`define MTS_TICK_CYC (`MTS_TICK_US * (`MTS_CLK_HZ / 1000000))

// Automatic settling delays in microseconds
`define MTS_DLY_1P0MS_US 1000
`define MTS_DLY_1P5MS_US 1500
`define MTS_DLY_10MS_US 10000
`define MTS_DLY_15MS_US 15000
`define MTS_DLY_100MS_US 100000
`define MTS_DLY_200MS_US 200000
`define MTS_DLY_600MS_US 600000
`define MTS_DLY_1P0S_US 1000000
`define MTS_DLY_1P5S_US 1500000
`define MTS_DLY_7P0S_US 7000000
`define MTS_DLY_TICKS(us) ((us) / `MTS_TICK_US)

`endif

//--- include/mts_pkg.sv
// Types shared by the trigger sequencer and its bench.
// Assumes mts_map.svh sits on the include path.
`include "mts_map.svh"

package mts_pkg;

    typedef enum logic [2:0] {
        MTS_SRC_AUTO,
        MTS_SRC_IMMEDIATE,
        MTS_SRC_SINGLE,
        MTS_SRC_EXTERNAL,
        MTS_SRC_BUS
    } mts_src_t;

    typedef enum logic [1:0] {
        MTS_FN_DC,
        MTS_FN_RES,
        MTS_FN_AC,
        MTS_FN_FREQ
    } mts_func_t;

    typedef enum logic [2:0] {
        MTS_ST_IDLE,
        MTS_ST_WAIT,
        MTS_ST_DELAY,
        MTS_ST_REQ,
        MTS_ST_READ
    } mts_state_t;

    typedef struct packed {
        logic shift;
        logic auto_trigger_settings_menu;
        logic single;
    } mts_keys_t;

    typedef struct packed {
        mts_func_t func;
        logic plc_ge1;
        logic [1:0] res_rng;
        logic [1:0] ac_filt;
    } mts_meas_cfg_t;

    typedef struct packed {
        logic valid;
        logic [23:0] data;
    } mts_reading_t;

    typedef struct packed {
        logic hold;
        logic [23:0] value;
    } mts_disp_t;

endpackage

//--- verification/mts_assertions.sv
// Port-level checks of mts_top, bound into every instance.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module mts_checker (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire mts_pkg::mts_keys_t keys_i,
    input wire mts_pkg::mts_reading_t meas_i,
    input wire logic meas_start_o,
    input wire mts_pkg::mts_disp_t disp_o,
    input wire logic beep_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // A second request before the answer would lose a reading
    logic busy_q;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_q <= 1'b0;
        end else if (meas_start_o) begin
            busy_q <= 1'b1;
        end else if (meas_i.valid) begin
            busy_q <= 1'b0;
        end
    end
    a_rdata_idle:
        assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data seen outside its slot");
    a_start_single:
        assert property (meas_start_o |=> !meas_start_o)
        else $error("reading request longer than one cycle");
    a_start_paired:
        assert property (meas_start_o |-> !busy_q)
        else $error("reading requested before previous answer");
    a_beep_when_hold:
        assert property (beep_o |-> disp_o.hold && !$past(beep_o))
        else $error("beep without hold or longer than one cycle");
    a_beep_after_read:
        assert property (beep_o |-> $past(meas_i.valid))
        else $error("beep not tied to a reading");
    a_freeze_beep:
        assert property (disp_o.hold && $past(disp_o.hold) &&
            !$stable(disp_o.value) |-> beep_o)
        else $error("held value changed without a beep");
    a_hold_on_key:
        assert property (keys_i.shift && keys_i.auto_trigger_settings_menu |-> ##2 disp_o.hold)
        else $error("shift with auto key did not enable hold");
    a_hold_off_key:
        assert property (!keys_i.shift && keys_i.auto_trigger_settings_menu
            |-> ##2 !disp_o.hold)
        else $error("auto key did not disable hold");
    a_display_follows:
        assert property (meas_i.valid && !disp_o.hold && !keys_i.auto_trigger_settings_menu
            && !$past(keys_i.auto_trigger_settings_menu)
            |=> disp_o.value == $past(meas_i.data))
        else $error("display did not follow reading with hold off");
endmodule // mts_checker
bind mts_top mts_checker u_mts_checker (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .keys_i(keys_i), .meas_i(meas_i),
    .meas_start_o(meas_start_o), .disp_o(disp_o), .beep_o(beep_o));
`default_nettype wire

//--- verification/mts_front_model.sv
// Front-end stand-in: answers each reading request after a latency.
// Assumes start_i is a one-cycle pulse synchronous to sys_clk_i.
`timescale 1ns/100ps
`default_nettype none
module mts_front_model (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire logic [3:0] lat_i,
    input wire logic [23:0] data_i,
    output var mts_pkg::mts_reading_t meas_o
);
    logic pend_q;
    logic [3:0] cnt_q;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pend_q <= 1'b0;
            cnt_q <= 4'h0;
            meas_o <= '0;
        end else begin
            meas_o.valid <= 1'b0;
            // Data is not held once the pulse is over
            meas_o.data <= ~meas_o.data;
            if (start_i) begin
                pend_q <= 1'b1;
                cnt_q <= lat_i;
            end else if (pend_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (pend_q) begin
                pend_q <= 1'b0;
                meas_o <= {1'b1, data_i};
            end
        end
    end
endmodule // mts_front_model
`default_nettype wire

//--- verification/mts_top_tb.sv
// Self-checking bench for mts_top with a front-end model beside it.
// Assumes the checker is bound in and mts_map.svh is on the path.
`timescale 1ns/100ps
`default_nettype none
`include "mts_map.svh"
module mts_top_tb;
    logic sys_clk_i, reset_n_i, reg_wr_i, reg_rd_i, external_trigger_input_i;
    logic meas_start_o, beep_o, trigger_settings_menu_ready_o, far_mode;
    logic [4:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, rv;
    logic [3:0] fe_lat;
    logic [23:0] fe_data;
    mts_pkg::mts_keys_t keys_i;
    mts_pkg::mts_reading_t meas_i;
    mts_pkg::mts_disp_t disp_o;
    integer seed, n_fail, cmp_count, cyc, n_starts, n_beeps, first_t, mark;
    integer i;
    mts_top u_mts_top (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .keys_i(keys_i), .external_trigger_input_i(external_trigger_input_i),
        .meas_i(meas_i), .meas_start_o(meas_start_o), .disp_o(disp_o),
        .beep_o(beep_o), .trigger_settings_menu_ready_o(trigger_settings_menu_ready_o));
    mts_front_model u_mts_front_model (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .start_i(meas_start_o),
        .lat_i(fe_lat), .data_i(fe_data), .meas_o(meas_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    // Each answer gets the random latency drawn at the request before it, and a random value unless far_mode steps it up by 0x100
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (meas_start_o) begin
            n_starts = n_starts + 1;
            if (first_t < 0) first_t = cyc;
            fe_lat <= 4'($random(seed) & 7);
            fe_data <= far_mode ? fe_data + 24'h000100
                : 24'h123450 + 24'($random(seed) & 3);
        end
        if (beep_o) n_beeps = n_beeps + 1;
        if (cyc == 80000) begin
            n_fail = n_fail + 1;
            wrap_up();
        end
    end
    task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input logic [31:0] got, lo, hi);
        cmp_count = cmp_count + 1;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        #1 mark = cyc;
        @(posedge sys_clk_i);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
        @(posedge sys_clk_i);
    endtask
    task automatic wait_starts(input integer n, input integer lim);
        integer k;
        for (k = 0; k < lim && n_starts < n; k++) @(posedge sys_clk_i);
        chk_in(n_starts, n, 32'hffff);
    endtask
    task automatic wait_idle;
        logic [31:0] s;
        integer k;
        s = 32'h1;
        for (k = 0; k < 60 && s[2:0] !== 3'h0; k++) rd(`MTS_OFF_STATUS, s);
        chk_eq(s[2:0], 32'h0);
    endtask
    task automatic wrap_up;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        seed = 89127;
        {n_fail, cmp_count, cyc, n_starts, n_beeps, mark} = '0;
        first_t = -1;
        far_mode = 1'b0;
        fe_lat = 4'h2;
        fe_data = 24'h123450;
        {reset_n_i, reg_wr_i, reg_rd_i, external_trigger_input_i} = 4'h0;
        reg_addr_i = 5'h00;
        reg_wdata_i = 32'h0;
        keys_i = '0;
        repeat (5) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        #1 mark = cyc;
        @(posedge sys_clk_i);
        rd(`MTS_OFF_CTRL, rv);
        chk_eq(rv, 32'h00000008);
        rd(`MTS_OFF_SCOUNT, rv);
        chk_eq(rv, 32'h00000001);
        rd(`MTS_OFF_TCOUNT, rv);
        chk_eq(rv, 32'h00000001);
        rd(5'h02, rv);
        chk_eq(rv, 32'h0);
        wait_starts(1, 41000);
        chk_in(first_t - mark, 39990, 40020);
        // Leave the self-running pass before its next 1 ms wait starts
        wr(`MTS_OFF_CTRL, 32'h1);
        wait_idle();
        wr(`MTS_OFF_CTRL, 32'h9);
        wr(`MTS_OFF_SCOUNT, 32'h0);
        wr(`MTS_OFF_SCOUNT, 32'd50001);
        rd(`MTS_OFF_SCOUNT, rv);
        chk_eq(rv, 32'h1);
        wr(`MTS_OFF_SCOUNT, 32'd50000);
        rd(`MTS_OFF_SCOUNT, rv);
        chk_eq(rv, 32'h0000c350);
        wr(`MTS_OFF_TCOUNT, 32'h0);
        rd(`MTS_OFF_TCOUNT, rv);
        chk_eq(rv, 32'h1);
        wr(`MTS_OFF_DELAY, 32'd36000000);
        wr(`MTS_OFF_DELAY, 32'd36000001);
        rd(`MTS_OFF_DELAY, rv);
        chk_eq(rv, 32'd36000000);
        rd(`MTS_OFF_CTRL, rv);
        chk_eq(rv, 32'h1);
        wr(`MTS_OFF_SCOUNT, 32'h3);
        wr(`MTS_OFF_TCOUNT, 32'h2);
        wr(`MTS_OFF_DELAY, 32'h2);
        n_starts = 0;
        first_t = -1;
        wr(`MTS_OFF_CTRL, 32'h11);
        wait_starts(6, 17000);
        chk_in(first_t - mark, 7995, 8010);
        repeat (100) @(posedge sys_clk_i);
        chk_eq(n_starts, 6);
        wait_idle();
        wr(`MTS_OFF_DELAY, 32'h0);
        wr(`MTS_OFF_SCOUNT, 32'h1);
        wr(`MTS_OFF_TCOUNT, 32'h1);
        n_starts = 0;
        wr(`MTS_OFF_CTRL, 32'h14);
        repeat (40) @(posedge sys_clk_i);
        chk_eq(trigger_settings_menu_ready_o, 32'h1);
        chk_eq(n_starts, 0);
        wr(`MTS_OFF_CTRL, 32'h24);
        wait_starts(1, 20);
        wait_idle();
        wr(`MTS_OFF_CTRL, 32'h3);
        repeat (8) @(posedge sys_clk_i);
        for (i = 2; i <= 3; i++) begin
            external_trigger_input_i <= 1'b1;
            @(posedge sys_clk_i);
            external_trigger_input_i <= 1'b0;
            wait_starts(i, 40);
            repeat (30) @(posedge sys_clk_i);
        end
        wr(`MTS_OFF_MEAS, 32'h3);
        wr(`MTS_OFF_BAND, 32'h4);
        wr(`MTS_OFF_CTRL, 32'h8);
        keys_i <= mts_pkg::mts_keys_t'(3'b110);
        @(posedge sys_clk_i);
        keys_i <= '0;
        @(posedge sys_clk_i);
        n_starts = 0;
        n_beeps = 0;
        wait_starts(30, 3000);
        chk_in(n_beeps, 8, 11);
        chk_eq(disp_o.hold, 32'h1);
        rd(`MTS_OFF_HELD, rv);
        chk_in(rv, 32'h123450, 32'h123453);
        far_mode = 1'b1;
        wait_starts(n_starts + 3, 300);
        n_beeps = 0;
        wait_starts(n_starts + 12, 1000);
        chk_eq(n_beeps, 0);
        keys_i <= mts_pkg::mts_keys_t'(3'b010);
        @(posedge sys_clk_i);
        keys_i <= '0;
        @(posedge sys_clk_i);
        rd(`MTS_OFF_STATUS, rv);
        chk_eq(rv[3], 32'h0);
        wr(`MTS_OFF_SCOUNT, 32'h5);
        wr(`MTS_OFF_DELAY, 32'h3);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        @(posedge sys_clk_i);
        rd(`MTS_OFF_CTRL, rv);
        chk_eq(rv, 32'h8);
        rd(`MTS_OFF_SCOUNT, rv);
        chk_eq(rv, 32'h1);
        rd(`MTS_OFF_DELAY, rv);
        chk_eq(rv, 32'h0);
        wrap_up();
    end
endmodule // mts_top_tb
`default_nettype wire
